// file: hw/sensor_two_wire_slave_port.sv
// Purpose: two-wire slave port and measurement sequencing of a pressure sensor
// Assumes: pins asynchronous to i_clk; signal processor is external logic
// Notes:   sda is open drain, only ever pulled low; config is latched once
`timescale 1ns/100ps

// Behaviour
// - continuous mode converts at selected rate; sleep mode converts once after start-up, then only on request.
// - either mode works with either interface; selection is fixed configuration; here requests come only over two-wire, so spi sleep mode converts once.
// - port accepts a measurement-request write and a result-fetch read.
// - bit rate 400kHz or 100kHz; master must not exceed the limit.
// - start then stop without clock pulse makes the next transfer fail.
// - repeated start makes the following transfer fail until a stop and a new start.
// - calibration and configuration store is locked, never written through the port.
// - processed pressure and temperature are both offered for output.
// - after a valid result is read, status shows stale until new data.
// - in two-wire mode the interrupt rises when fresh valid data is ready.
module sensor_two_wire_slave_port
	import sensor_port_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR  = 7'h28,	// arbitrary value
	parameter int         STARTUP_N   = sensor_port_pkg::STARTUP_CYC,
	parameter int         UPD0_N      = sensor_port_pkg::UPD0_US * sensor_port_pkg::CLK_MHZ,
	parameter int         UPD1_N      = sensor_port_pkg::UPD1_US * sensor_port_pkg::CLK_MHZ,
	parameter int         UPD2_N      = sensor_port_pkg::UPD2_US * sensor_port_pkg::CLK_MHZ,
	parameter int         UPD3_N      = sensor_port_pkg::UPD3_US * sensor_port_pkg::CLK_MHZ
) (
	input  wire logic                              i_clk,        // system clock
	input  wire logic                              i_sys_rst,    // sync reset, high
	input  wire logic                              i_scl,        // clock pin
	input  wire logic                              i_sda,        // data pin level
	output logic                                   o_sda,        // data drive value
	output logic                                   o_sda_oe,     // high pulls sda
	output logic                                   o_int,        // fresh data ready
	input  wire logic                              i_cfg_two_wire, // 1 two-wire, 0 spi
	input  wire logic                              i_cfg_sleep,  // 1 sleep mode
	input  wire logic [1:0]                        i_cfg_rate,   // update rate code
	output logic                                   o_meas_start, // conversion request
	input  wire logic                              i_meas_done,  // conversion done
	input  wire logic [sensor_port_pkg::PRES_W-1:0] i_pressure,  // corrected pressure
	input  wire logic [sensor_port_pkg::TEMP_W-1:0] i_temp       // temperature
);
	import sensor_port_pkg::*;

	if (UPD3_N >= (1 << TMR_W) || STARTUP_N >= (1 << TMR_W) || UPD0_N < 1) begin : g_chk_tmr
		$error("timer counts do not fit the timer width");
	end
	if (SCL_FAST_KHZ * MIN_OVERSAMPLE > CLK_KHZ) begin : g_chk_rate
		$error("clock too slow to oversample the fast bit rate");
	end

	typedef struct packed {
		logic [1:0]             scl_s;
		logic [1:0]             sda_s;
		logic                   scl_d;
		logic                   sda_d;
		port_state_t            st;
		logic [3:0]             bitcnt;
		logic [7:0]             shreg;
		logic                   rw;
		logic [1:0]             byte_idx;
		logic                   clk_seen;
		logic                   err_pend;
		logic                   acked;
		logic                   sda_oe;
		logic                   meas_start;
		logic                   busy;
		logic [1:0]             status;
		logic [PRES_W-1:0]      pres;
		logic [TEMP_W-1:0]      temp;
		logic                   irq;
		logic [TMR_W-1:0]       tmr;
		logic                   started;
		logic                   cfg_lat;
		logic                   cfg_two_wire;
		logic                   cfg_sleep;
		logic [1:0]             cfg_rate;
	} port_regs_t;

	port_regs_t r_ff;
	port_regs_t nxt_r;
	logic       start_ev;
	logic       stop_ev;
	logic       scl_rise;
	logic       scl_fall;
	logic       fetch_done;
	logic       meas_req;

	function automatic logic [7:0] result_byte(input logic [1:0] idx, input port_regs_t s);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			2'h0:    b = {s.status, s.pres[PRES_W-1:8]};
			2'h1:    b = s.pres[7:0];
			2'h2:    b = s.temp[TEMP_W-1:3];
			default: b = {s.temp[2:0], 5'h00};
		endcase
		return b;
	endfunction

	function automatic logic [TMR_W-1:0] period_cyc(input logic [1:0] rate);
		logic [TMR_W-1:0] p;
		p = TMR_W'(UPD0_N);
		case (rate)
			2'h1:    p = TMR_W'(UPD1_N);
			2'h2:    p = TMR_W'(UPD2_N);
			2'h3:    p = TMR_W'(UPD3_N);
			default: p = TMR_W'(UPD0_N);
		endcase
		return p;
	endfunction

	always_comb begin
		nxt_r      = r_ff;
		// second sync stage feeds edge logic and data sampling; first stage is read by nothing else
		nxt_r.scl_s = {r_ff.scl_s[0], i_scl};
		nxt_r.sda_s = {r_ff.sda_s[0], i_sda};
		nxt_r.scl_d = r_ff.scl_s[1];
		nxt_r.sda_d = r_ff.sda_s[1];
		start_ev   = r_ff.scl_s[1] && r_ff.scl_d && r_ff.sda_d && !r_ff.sda_s[1];
		stop_ev    = r_ff.scl_s[1] && r_ff.scl_d && !r_ff.sda_d && r_ff.sda_s[1];
		scl_rise   = r_ff.scl_s[1] && !r_ff.scl_d;
		scl_fall   = !r_ff.scl_s[1] && r_ff.scl_d;
		fetch_done = 1'b0;
		meas_req   = 1'b0;
		nxt_r.meas_start = 1'b0;

		// configuration is taken once after reset and never rewritten
		if (!r_ff.cfg_lat) begin
			nxt_r.cfg_lat      = 1'b1;
			nxt_r.cfg_two_wire = i_cfg_two_wire;
			nxt_r.cfg_sleep    = i_cfg_sleep;
			nxt_r.cfg_rate     = i_cfg_rate;
		end

		if (scl_rise) begin
			nxt_r.clk_seen = 1'b1;
		end

		if (!r_ff.cfg_two_wire) begin
			nxt_r.st     = S_IDLE;
			nxt_r.sda_oe = 1'b0;
		end else if (start_ev) begin
			// restart mid-transfer or a pending fault spoils this transfer
			if (r_ff.err_pend || r_ff.st != S_IDLE) begin
				nxt_r.st = S_IGNORE;
			end else begin
				nxt_r.st = S_ADDR;
			end
			nxt_r.err_pend = 1'b0;
			nxt_r.clk_seen = 1'b0;
			nxt_r.bitcnt   = 4'h0;
			nxt_r.sda_oe   = 1'b0;
		end else if (stop_ev) begin
			if (r_ff.st != S_IDLE && !r_ff.clk_seen) begin
				nxt_r.err_pend = 1'b1;
			end
			nxt_r.st     = S_IDLE;
			nxt_r.sda_oe = 1'b0;
		end else begin
			case (r_ff.st)
				S_ADDR: begin
					if (scl_rise) begin
						nxt_r.shreg  = {r_ff.shreg[6:0], r_ff.sda_s[1]};
						nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
					end else if (scl_fall && r_ff.bitcnt == BITS_PER_BYTE) begin
						nxt_r.rw = r_ff.shreg[RW_BIT];
						if (r_ff.shreg[ADDR_MSB:1] == SLAVE_ADDR) begin
							nxt_r.st     = S_AACK;
							nxt_r.sda_oe = 1'b1;
						end else begin
							nxt_r.st = S_IGNORE;
						end
					end
				end
				S_AACK: begin
					if (scl_fall) begin
						nxt_r.bitcnt = 4'h0;
						if (r_ff.rw) begin
							nxt_r.st       = S_TX;
							nxt_r.byte_idx = 2'h0;
							nxt_r.shreg    = result_byte(2'h0, r_ff);
							nxt_r.sda_oe   = !nxt_r.shreg[7];
						end else begin
							// write with no payload is the measurement request
							meas_req     = 1'b1;
							nxt_r.st     = S_IGNORE;
							nxt_r.sda_oe = 1'b0;
						end
					end
				end
				S_TX: begin
					if (scl_rise) begin
						nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (r_ff.bitcnt == BITS_PER_BYTE) begin
							nxt_r.st     = S_TACK;
							nxt_r.sda_oe = 1'b0;
						end else begin
							nxt_r.shreg  = {r_ff.shreg[6:0], 1'b0};
							nxt_r.sda_oe = !r_ff.shreg[6];
						end
					end
				end
				S_TACK: begin
					if (scl_rise) begin
						nxt_r.acked = !r_ff.sda_s[1];
						fetch_done  = (r_ff.byte_idx == 2'h0);
					end else if (scl_fall) begin
						if (r_ff.acked) begin
							nxt_r.byte_idx = (r_ff.byte_idx == 2'(RES_BYTES - 1)) ?
								r_ff.byte_idx : r_ff.byte_idx + 2'h1;
							nxt_r.shreg    = result_byte(nxt_r.byte_idx, r_ff);
							nxt_r.sda_oe   = !nxt_r.shreg[7];
							nxt_r.bitcnt   = 4'h0;
							nxt_r.st       = S_TX;
						end else begin
							nxt_r.st = S_IGNORE;
						end
					end
				end
				S_IGNORE: nxt_r.sda_oe = 1'b0;
				default:  nxt_r.st = S_IDLE;
			endcase
		end

		// measurement sequencing
		if (!r_ff.started) begin
			nxt_r.tmr = r_ff.tmr - TMR_W'(1);
			if (r_ff.tmr == '0) begin
				nxt_r.started    = 1'b1;
				nxt_r.meas_start = 1'b1;
				nxt_r.busy       = 1'b1;
				nxt_r.tmr        = period_cyc(r_ff.cfg_rate) - TMR_W'(1);
			end
		end else if (!r_ff.cfg_sleep) begin
			if (r_ff.tmr != '0) begin
				nxt_r.tmr = r_ff.tmr - TMR_W'(1);
			end else if (!r_ff.busy) begin
				// reload one short: the zero cycle itself closes the period
				nxt_r.meas_start = 1'b1;
				nxt_r.busy       = 1'b1;
				nxt_r.tmr        = period_cyc(r_ff.cfg_rate) - TMR_W'(1);
			end
		end else if (meas_req && !r_ff.busy) begin
			nxt_r.meas_start = 1'b1;
			nxt_r.busy       = 1'b1;
		end

		// a read marks stale, but a fresh result in the same cycle wins
		if (fetch_done && r_ff.status == STAT_VALID) begin
			nxt_r.status = STAT_STALE;
			nxt_r.irq    = 1'b0;
		end
		if (i_meas_done && r_ff.busy) begin
			nxt_r.busy   = 1'b0;
			nxt_r.pres   = i_pressure;
			nxt_r.temp   = i_temp;
			nxt_r.status = STAT_VALID;
			nxt_r.irq    = r_ff.cfg_two_wire;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			r_ff              <= '0;
			r_ff.scl_s        <= 2'h3;
			r_ff.sda_s        <= 2'h3;
			r_ff.scl_d        <= 1'b1;
			r_ff.sda_d        <= 1'b1;
			r_ff.st           <= S_IDLE;
			r_ff.status       <= STAT_RST;
			r_ff.cfg_rate     <= RATE_RST;
			r_ff.tmr          <= TMR_W'(STARTUP_N);
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign o_sda        = 1'b0;
	assign o_sda_oe     = r_ff.sda_oe;
	assign o_int        = r_ff.irq;
	assign o_meas_start = r_ff.meas_start;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence bare_stop_s;
		stop_ev && r_ff.st != S_IDLE && !r_ff.clk_seen;
	endsequence
	sequence next_start_s;
		start_ev && r_ff.cfg_two_wire;
	endsequence

	boot_quiet_a: assert property (!r_ff.started |-> !o_meas_start)
		else $error("conversion requested during start-up");
	bare_stop_flag_a: assert property ((bare_stop_s and r_ff.cfg_two_wire) |=> r_ff.err_pend)
		else $error("bare start-stop not remembered");
	restart_ignore_a: assert property (next_start_s and r_ff.st != S_IDLE |=> r_ff.st == S_IGNORE)
		else $error("restart did not spoil the transfer");
	pend_consume_a: assert property (next_start_s and r_ff.err_pend
		|=> r_ff.st == S_IGNORE && !r_ff.err_pend)
		else $error("pending fault not applied to next transfer");
	ignore_silent_a: assert property (r_ff.st == S_IGNORE |=> !o_sda_oe)
		else $error("ignored transfer drove sda");
	addr_ack_a: assert property ($rose(r_ff.st == S_AACK) |-> o_sda_oe ##1 o_sda_oe)
		else $error("address not acknowledged");
	stale_read_a: assert property (fetch_done && r_ff.status == STAT_VALID && !i_meas_done
		|=> r_ff.status == STAT_STALE && !o_int)
		else $error("read did not mark data stale");
	int_fresh_a: assert property (i_meas_done && r_ff.busy && r_ff.cfg_two_wire
		|=> o_int && r_ff.status == STAT_VALID)
		else $error("interrupt missing on fresh data");
	sleep_single_a: assert property (r_ff.started && r_ff.cfg_sleep && !meas_req
		|=> !o_meas_start)
		else $error("sleep mode converted without request");
	cfg_locked_a: assert property (r_ff.cfg_lat |=> $stable(r_ff.cfg_rate) && $stable(r_ff.cfg_sleep))
		else $error("locked configuration changed");
	upd_pulse_a: assert property (o_meas_start |=> !o_meas_start [*2])
		else $error("conversion request not a single pulse");
	spi_quiet_a: assert property (!r_ff.cfg_two_wire |=> !o_sda_oe && !o_int)
		else $error("two-wire port active in spi configuration");

endmodule

// file: hw/sensor_port_pkg.sv
// Purpose: shared constants and types of the sensor two-wire slave port
// Assumes: 25 MHz system clock; times held in their printed units
// Notes:   counts above 4096 cycles are top-level parameters
package sensor_port_pkg;

	localparam int CLK_KHZ        = 25000;
	localparam int CLK_MHZ        = 25;
	// bit rates on the wire
	localparam int SCL_FAST_KHZ   = 400;
	localparam int SCL_STD_KHZ    = 100;
	localparam int MIN_OVERSAMPLE = 8;
	// start-up quiet time before the first conversion
	localparam int STARTUP_MS     = 10;
	localparam int STARTUP_CYC    = STARTUP_MS * CLK_KHZ;
	// update periods per rate setting, in microseconds
	localparam int UPD0_US        = 500;
	localparam int UPD1_US        = 1500;
	localparam int UPD2_US        = 6500;
	localparam int UPD3_US        = 32000;
	localparam int TMR_W          = 20;
	// result status field
	localparam logic [1:0] STAT_VALID = 2'h0;
	localparam logic [1:0] STAT_STALE = 2'h2;
	localparam logic [1:0] STAT_RST   = STAT_STALE;
	localparam int PRES_W         = 14;
	localparam int TEMP_W         = 11;
	localparam int RES_BYTES      = 4;
	localparam logic [1:0] RATE_RST   = 2'h0;
	// address byte field positions
	localparam int ADDR_MSB       = 7;
	localparam int RW_BIT         = 0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_AACK,
		S_TX,
		S_TACK,
		S_IGNORE
	} port_state_t;

endpackage

// file: tb/two_wire_master.sv
// Purpose: behavioural two-wire bus master for the sensor port bench
// Assumes: sda has a pull-up; o_sda low pulls the wire low
// Notes:   16 clocks a quarter bit keeps the rate just under 400 kHz
`timescale 1ns/100ps
module two_wire_master #(
	parameter int Q = 16
) (
	input  wire logic i_clk,	// system clock
	input  wire logic i_sda,	// resolved wire level
	output logic      o_scl,	// clock line
	output logic      o_sda	// 0 pulls data low
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic drive(input logic c, input logic d);
		o_scl = c;
		o_sda = d;
		repeat (Q) @(posedge i_clk);
		#1;
	endtask
	// sda stays low into the first bit, so a leading zero needs no fall
	task automatic start();
		drive(1'b1, 1'b1);
		drive(1'b1, 1'b0);
		drive(1'b0, 1'b0);
	endtask
	// scl falls before sda moves, never both in one step
	task automatic clk_bit(input logic b, output logic r);
		drive(1'b0, b);
		drive(1'b1, b);
		r = i_sda;
		drive(1'b1, b);
		drive(1'b0, b);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], r[i]);
		clk_bit(ack_in, ack);
	endtask
	task automatic stop();
		drive(1'b0, 1'b0);
		drive(1'b1, 1'b0);
		drive(1'b1, 1'b1);
		repeat (3) drive(1'b1, 1'b1);
	endtask
	task automatic restart();
		drive(1'b0, 1'b1);
		drive(1'b1, 1'b1);
		drive(1'b1, 1'b0);
		drive(1'b0, 1'b0);
	endtask
	task automatic bare();
		drive(1'b1, 1'b0);
		drive(1'b1, 1'b1);
		repeat (3) drive(1'b1, 1'b1);
	endtask
endmodule

// file: tb/sensor_two_wire_slave_port_bench.sv
// Purpose: self-checking bench of the sensor two-wire slave port
// Assumes: short startup and update counts set through parameters
// Notes:   processor stand-in answers each request four clocks later
`timescale 1ns/100ps
module sensor_two_wire_slave_port_bench;
	import sensor_port_pkg::*;
	localparam logic [6:0] ADDR = 7'h28;	// arbitrary value
	localparam int UPD [4] = '{40, 60, 80, 100};
	logic              i_clk = 1'b0;
	logic              i_sys_rst = 1'b1;
	logic              scl;
	logic              m_sda;
	logic              o_sda;
	logic              o_sda_oe;
	logic              o_int;
	logic              cfg_two_wire = 1'b1;
	logic              cfg_sleep = 1'b1;
	logic [1:0]        cfg_rate = 2'h0;
	logic              o_meas_start;
	logic              i_meas_done = 1'b0;
	logic [PRES_W-1:0] i_pressure = 14'h0000;
	logic [TEMP_W-1:0] i_temp = 11'h000;
	wire               sda_w = m_sda & ~(o_sda_oe & ~o_sda);
	int                n_fail = 0;
	int                checks = 0;
	int                n_meas = 0;
	int                cyc = 0;
	int                last_st = 0;
	int                gap = 0;
	int                dly = 0;

	sensor_two_wire_slave_port #(.SLAVE_ADDR(ADDR), .STARTUP_N(50), .UPD0_N(UPD[0]),
		.UPD1_N(UPD[1]), .UPD2_N(UPD[2]), .UPD3_N(UPD[3])) u_sensor_two_wire_slave_port (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda),
		.o_sda_oe(o_sda_oe), .o_int(o_int), .i_cfg_two_wire(cfg_two_wire),
		.i_cfg_sleep(cfg_sleep), .i_cfg_rate(cfg_rate), .o_meas_start(o_meas_start),
		.i_meas_done(i_meas_done), .i_pressure(i_pressure), .i_temp(i_temp));
	two_wire_master u_two_wire_master (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl),
		.o_sda(m_sda));

	always #20 i_clk = ~i_clk;
	// processor stand-in and run limit
	always @(posedge i_clk) begin
		#1;
		cyc++;
		i_meas_done = 1'b0;
		if (dly == 1) begin
			i_meas_done = 1'b1;
			i_pressure = 14'h1a30 + 14'(n_meas);
			i_temp = 11'h5c3 - 11'(n_meas);
		end
		if (dly > 0) dly--;
		if (o_meas_start === 1'b1) begin
			n_meas++;
			gap = cyc - last_st;
			last_st = cyc;
			dly = 4;
		end
		if (cyc == 60000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (n_fail == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rst(input logic tw, input logic sl, input logic [1:0] rt);
		i_sys_rst = 1'b1;
		cfg_two_wire = tw;
		cfg_sleep = sl;
		cfg_rate = rt;
		repeat (5) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		dly = 0;
		n_meas = 0;
	endtask
	task automatic wait_int();
		// sample off the edge so a same-edge update never races the test
		for (int k = 0; k < 400 && o_int !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
	endtask
	task automatic probe(input logic [7:0] ab, output logic a);
		logic [7:0] r;
		logic       a2;
		u_two_wire_master.start();
		u_two_wire_master.xfer(ab, 1'b1, r, a);
		if (ab[0]) u_two_wire_master.xfer(8'hff, 1'b1, r, a2);
		u_two_wire_master.stop();
	endtask
	task automatic fetch(input logic [1:0] st);
		logic [7:0] r;
		logic       a;
		logic [7:0] exp [4];
		exp = '{{st, i_pressure[13:8]}, i_pressure[7:0], i_temp[10:3], {i_temp[2:0], 5'h00}};
		u_two_wire_master.start();
		u_two_wire_master.xfer({ADDR, 1'b1}, 1'b1, r, a);
		chk("fetch ack", 0, a);
		for (int i = 0; i < 4; i++) begin
			u_two_wire_master.xfer(8'hff, i == 3, r, a);
			chk("result byte", exp[i], r);
		end
		u_two_wire_master.stop();
	endtask
	task automatic sc_sleep();
		int   n0;
		logic a;
		rst(1'b1, 1'b1, 2'h0);
		wait_int();
		cfg_sleep = 1'b0;
		chk("int on fresh data", 1, o_int);
		fetch(STAT_VALID);
		chk("int after fetch", 0, o_int);
		fetch(STAT_STALE);
		n0 = n_meas;
		repeat (300) @(posedge i_clk);
		#1;
		chk("sleep stays idle", n0, n_meas);
		probe({ADDR, 1'b0}, a);
		chk("request ack", 0, a);
		wait_int();
		chk("one conversion", n0 + 1, n_meas);
		fetch(STAT_VALID);
	endtask
	task automatic sc_quirks();
		logic [7:0] r;
		logic       a;
		u_two_wire_master.bare();
		probe({ADDR, 1'b1}, a);
		chk("after bare start", 1, a);
		probe({ADDR, 1'b1}, a);
		chk("recovered", 0, a);
		u_two_wire_master.start();
		u_two_wire_master.xfer({ADDR, 1'b0}, 1'b1, r, a);
		u_two_wire_master.restart();
		u_two_wire_master.xfer({ADDR, 1'b1}, 1'b1, r, a);
		u_two_wire_master.stop();
		chk("after restart", 1, a);
		probe({ADDR, 1'b1}, a);
		chk("recovered", 0, a);
		probe({ADDR ^ 7'h01, 1'b1}, a);
		chk("other address", 1, a);
	endtask
	// rate 3 runs with the spi selection, so the port must stay silent
	task automatic sc_update();
		logic a;
		for (int rt = 0; rt < 4; rt++) begin
			rst(rt != 3, 1'b0, 2'(rt));
			for (int k = 0; k < 400 && n_meas < 2; k++) @(posedge i_clk);
			#1;
			chk("update period", UPD[rt], gap);
			chk("int by interface", rt != 3, o_int);
			probe({ADDR, 1'b1}, a);
			chk("ack by interface", rt == 3, a);
		end
	endtask
	initial begin
		sc_sleep();
		sc_quirks();
		sc_update();
		print_verdict();
	end
endmodule
